// ===== verilog/acos_pkg.sv
// constants, register map and timing counts for the four-axis command output stage
// assumes one 200 MHz clock and a plain word-wide register port from the local cpu
package acos_pkg;

    // clock and timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int STEP_MIN_NS   = 1000;
    localparam int DIR_SETUP_NS  = 200;
    localparam int STEP_MIN_CYC  = (STEP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DIR_SETUP_CYC = (DIR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // widths
    localparam int CMD_W  = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // per-axis register block: byte offset inside block, block stride
    localparam logic [7:0] AXIS_STRIDE = 8'h20;
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_POS_LIM = 8'h04;
    localparam logic [7:0] OFF_NEG_LIM = 8'h08;
    localparam logic [7:0] OFF_OFFSET  = 8'h0c;
    localparam logic [7:0] OFF_DIRECT  = 8'h10;
    localparam logic [7:0] OFF_STATUS  = 8'h14;
    localparam logic [7:0] OFF_STEPS   = 8'h18;

    // global registers
    localparam logic [7:0] ADDR_WIDTH  = 8'h80;
    localparam logic [7:0] ADDR_KCLR   = 8'h84;
    localparam logic [7:0] ADDR_KSTAT  = 8'h88;

    // control register fields
    localparam int CTRL_W        = 7;
    localparam int CTRL_MODE_CCW = 0;
    localparam int CTRL_PUL_POL  = 1;
    localparam int CTRL_DIR_POL  = 2;
    localparam int CTRL_INH_POL  = 3;
    localparam int CTRL_INH_SW   = 4;
    localparam int CTRL_AUTO_INH = 5;
    localparam int CTRL_MAPPED   = 6;

    // status register fields
    localparam int STAT_KILLED = 0;
    localparam int STAT_BUSY   = 1;
    localparam int STAT_INH    = 2;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST    = 7'h60;
    localparam logic [CMD_W-1:0]  POS_LIM_RST = 16'h7fff;
    localparam logic [CMD_W-1:0]  NEG_LIM_RST = 16'h8000;
    localparam logic [CMD_W-1:0]  WIDTH_RST   = 16'(STEP_MIN_CYC);

    typedef enum logic [3:0] {
        ACOS_IDLE   = 4'b0001,
        ACOS_SETUP  = 4'b0010,
        ACOS_ACTIVE = 4'b0100,
        ACOS_HOLD   = 4'b1000
    } acos_step_state_t;

endpackage : acos_pkg

// ===== verilog/acos_chan_if.sv
// carrier between the register/kill logic and one step pulse channel
// assumes both ends share clk_i
`timescale 1ns/1ps
interface acos_chan_if;
    logic        mode_ccw;
    logic        pulse_pol_high;
    logic        dir_pol_high;
    logic        block;
    logic [15:0] width;
    logic        step_valid;
    logic        step_fwd;
    logic        step_ready;
    logic        pulse_pin;
    logic        reverse_pin;
    logic        busy;
    logic [15:0] step_count;

    modport owner (
        output mode_ccw, pulse_pol_high, dir_pol_high, block, width, step_valid, step_fwd,
        input  step_ready, pulse_pin, reverse_pin, busy, step_count
    );
    modport chan (
        input  mode_ccw, pulse_pol_high, dir_pol_high, block, width, step_valid, step_fwd,
        output step_ready, pulse_pin, reverse_pin, busy, step_count
    );
endinterface : acos_chan_if

// ===== verilog/acos_step_chan.sv
// one stepper pulse channel: turns accepted steps into pin pulses
// assumes steps arrive as valid/ready from the trajectory generator
`timescale 1ns/1ps
module acos_step_chan (
    // clock and reset
    input  wire logic   clk_i,
    input  wire logic   reset_n_i,
    // channel carrier
    acos_chan_if.chan   c
);
    acos_pkg::acos_step_state_t state_reg;
    logic [15:0]                cnt_reg;
    logic                       dir_reg;
    logic [15:0]                count_reg;
    logic                       pulse_pin_reg;
    logic                       rev_pin_reg;
    logic [15:0]                width_m1;
    logic                       accept;
    logic                       turn;
    logic                       active;
    logic                       fwd_act;
    logic                       rev_act;
    logic [15:0]                act_len_reg;

    localparam logic [15:0] SETUP_M1 = 16'(acos_pkg::DIR_SETUP_CYC - 1);
    localparam int          SU_GO    = acos_pkg::DIR_SETUP_CYC + 1;

    // a zero width would give no pulse at all, so it acts as one cycle
    assign width_m1     = (c.width == 16'h0000) ? 16'h0000 : c.width - 16'h0001;
    assign c.step_ready = (state_reg == acos_pkg::ACOS_IDLE) && !c.block;
    assign accept       = c.step_valid && c.step_ready;
    assign turn         = accept && (c.step_fwd != dir_reg);
    assign active       = (state_reg == acos_pkg::ACOS_ACTIVE);
    assign c.busy       = (state_reg != acos_pkg::ACOS_IDLE);
    assign c.pulse_pin  = pulse_pin_reg;
    assign c.reverse_pin = rev_pin_reg;
    assign c.step_count = count_reg;

    // direction change inserts a setup phase so the drive sees a settled level
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_reg <= acos_pkg::ACOS_IDLE;
            cnt_reg   <= 16'h0000;
        end else begin
            case (state_reg)
                acos_pkg::ACOS_IDLE: begin
                    if (accept) begin
                        state_reg <= turn ? acos_pkg::ACOS_SETUP : acos_pkg::ACOS_ACTIVE;
                        cnt_reg   <= turn ? SETUP_M1 : width_m1;
                    end
                end
                acos_pkg::ACOS_SETUP: begin
                    if (cnt_reg == 16'h0000) begin
                        state_reg <= acos_pkg::ACOS_ACTIVE;
                        cnt_reg   <= width_m1;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                acos_pkg::ACOS_ACTIVE: begin
                    if (cnt_reg == 16'h0000) begin
                        state_reg <= acos_pkg::ACOS_HOLD;
                        cnt_reg   <= width_m1;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                acos_pkg::ACOS_HOLD: begin
                    if (cnt_reg == 16'h0000) begin
                        state_reg <= acos_pkg::ACOS_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                default: begin
                    state_reg <= acos_pkg::ACOS_IDLE;
                    cnt_reg   <= 16'h0000;
                end
            endcase
        end
    end

    // direction only moves on acceptance, never inside a pulse
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            dir_reg <= 1'b1;
        end else if (accept) begin
            dir_reg <= c.step_fwd;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            count_reg <= 16'h0000;
        end else if (active && cnt_reg == 16'h0000) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // mode picks what each pin carries
    always_comb begin
        if (c.mode_ccw) begin
            fwd_act = active && dir_reg;
            rev_act = active && !dir_reg;
        end else begin
            fwd_act = active;
            rev_act = !dir_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pulse_pin_reg <= 1'b1;
            rev_pin_reg   <= 1'b1;
        end else begin
            pulse_pin_reg <= fwd_act ~^ c.pulse_pol_high;
            rev_pin_reg   <= rev_act ~^ c.dir_pol_high;
        end
    end

    // helper: length of the active phase
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            act_len_reg <= 16'h0000;
        end else begin
            act_len_reg <= active ? act_len_reg + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence turn_s;
        turn;
    endsequence
    sequence fire_s;
        state_reg == acos_pkg::ACOS_ACTIVE;
    endsequence

    pulse_width_a: assert property ($fell(active) |-> $past(act_len_reg) == $past(width_m1))
        else $error("step pulse length differs from programmed width");
    dir_setup_a: assert property (turn_s |-> ##SU_GO fire_s)
        else $error("pulse not started after direction setup time");
    dir_stable_a: assert property (c.busy |=> $stable(dir_reg))
        else $error("direction moved during a step");
    one_step_a: assert property (accept |=> !c.step_ready ##0 c.busy)
        else $error("accepted step did not start a pulse sequence");
    step_count_a: assert property ($fell(active) |-> count_reg == $past(count_reg) + 16'h0001)
        else $error("pulse not counted exactly once");
    ccw_split_a: assert property ((c.mode_ccw && active && !dir_reg) |=> pulse_pin_reg != c.pulse_pol_high)
        else $error("forward pin pulsed on reverse motion");
    dir_level_a: assert property (!c.mode_ccw |=> rev_pin_reg == (!$past(dir_reg) ~^ $past(c.dir_pol_high)))
        else $error("direction pin does not show commanded sense");

endmodule : acos_step_chan

// ===== verilog/axis_command_output_stage.sv
// four-axis command output stage: step pins, drive-disable pins, servo values
// assumes a word register port with read data one cycle after the read strobe
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module axis_command_output_stage #(
    parameter int AXES = 4
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    reset_n_i,
    // register port
    input  wire logic [7:0]              reg_addr_i,
    input  wire logic [31:0]             reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    output logic      [31:0]             reg_rdata_o,
    // trajectory generator
    input  wire logic [AXES-1:0]         step_valid_i,
    input  wire logic [AXES-1:0]         step_fwd_i,
    output logic      [AXES-1:0]         step_ready_o,
    input  wire logic [AXES-1:0][15:0]   servo_cmd_i,
    // kill sources
    input  wire logic                    shutdown_i,
    input  wire logic                    stop_all_i,
    input  wire logic [AXES-1:0]         motion_err_i,
    // drive pins
    output logic      [AXES-1:0]         pulse_forward_out_o,
    output logic      [AXES-1:0]         sense_reverse_out_o,
    output logic      [AXES-1:0]         inhibit_out_o,
    output logic      [AXES-1:0][15:0]   servo_value_o
);
    // address decode only spans four axis blocks below the global area
    if (AXES < 1 || AXES > 4) begin : g_bad_axes
        $error("AXES must be 1 to 4");
    end

    logic [acos_pkg::CTRL_W-1:0] ctrl_reg   [AXES];
    logic [15:0]                 pos_reg    [AXES];
    logic [15:0]                 neg_reg    [AXES];
    logic [15:0]                 off_reg    [AXES];
    logic [15:0]                 direct_reg [AXES];
    logic [15:0]                 width_reg;
    logic [AXES-1:0]             killed_reg;
    logic [AXES-1:0]             killed_next;
    logic [AXES-1:0]             inh_act;
    logic [AXES-1:0]             inh_reg;
    logic [AXES-1:0][15:0]       servo_reg;
    logic [AXES-1:0][15:0]       servo_next;
    logic [AXES-1:0]             busy_w;
    logic [AXES-1:0][15:0]       count_w;
    logic [31:0]                 rd_val;
    logic [31:0]                 rdata_reg;

    acos_chan_if ch [AXES] ();

    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {a[15], a} + {b[15], b};
        if (s[16] != s[15]) begin
            sat_add = s[16] ? 16'h8000 : 16'h7fff;
        end else begin
            sat_add = s[15:0];
        end
    endfunction : sat_add

    function automatic logic [7:0] axis_addr(input int a, input logic [7:0] off);
        axis_addr = 8'(a) * acos_pkg::AXIS_STRIDE + off;
    endfunction : axis_addr

    // register writes
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            width_reg <= acos_pkg::WIDTH_RST;
            for (int a = 0; a < AXES; a++) begin
                ctrl_reg[a]   <= acos_pkg::CTRL_RST;
                pos_reg[a]    <= acos_pkg::POS_LIM_RST;
                neg_reg[a]    <= acos_pkg::NEG_LIM_RST;
                off_reg[a]    <= 16'h0000;
                direct_reg[a] <= 16'h0000;
            end
        end else if (reg_wr_i) begin
            if (reg_addr_i == acos_pkg::ADDR_WIDTH) begin
                width_reg <= reg_wdata_i[15:0];
            end
            for (int a = 0; a < AXES; a++) begin
                if (reg_addr_i == axis_addr(a, acos_pkg::OFF_CTRL)) begin
                    ctrl_reg[a] <= reg_wdata_i[acos_pkg::CTRL_W-1:0];
                end else if (reg_addr_i == axis_addr(a, acos_pkg::OFF_POS_LIM)) begin
                    pos_reg[a] <= reg_wdata_i[15:0];
                end else if (reg_addr_i == axis_addr(a, acos_pkg::OFF_NEG_LIM)) begin
                    neg_reg[a] <= reg_wdata_i[15:0];
                end else if (reg_addr_i == axis_addr(a, acos_pkg::OFF_OFFSET)) begin
                    off_reg[a] <= reg_wdata_i[15:0];
                end else if (reg_addr_i == axis_addr(a, acos_pkg::OFF_DIRECT)) begin
                    direct_reg[a] <= reg_wdata_i[15:0];
                end
            end
        end
    end

    // kill latch: a new kill event wins over a clear in the same cycle
    always_comb begin
        killed_next = killed_reg;
        if (reg_wr_i && reg_addr_i == acos_pkg::ADDR_KCLR) begin
            killed_next = killed_reg & ~reg_wdata_i[AXES-1:0];
        end
        killed_next = killed_next | motion_err_i;
        if (shutdown_i || stop_all_i) begin
            killed_next = {AXES{1'b1}};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            killed_reg <= '0;
        end else begin
            killed_reg <= killed_next;
        end
    end

    // drive-disable pins and servo values
    always_comb begin
        for (int a = 0; a < AXES; a++) begin
            inh_act[a] = ctrl_reg[a][acos_pkg::CTRL_INH_SW]
                       || (ctrl_reg[a][acos_pkg::CTRL_AUTO_INH] && killed_reg[a]);
            if (!ctrl_reg[a][acos_pkg::CTRL_MAPPED]) begin
                servo_next[a] = direct_reg[a];
            end else if ($signed(servo_cmd_i[a]) > $signed(pos_reg[a])) begin
                servo_next[a] = sat_add(pos_reg[a], off_reg[a]);
            end else if ($signed(servo_cmd_i[a]) < $signed(neg_reg[a])) begin
                servo_next[a] = sat_add(neg_reg[a], off_reg[a]);
            end else begin
                servo_next[a] = sat_add(servo_cmd_i[a], off_reg[a]);
            end
        end
    end

    // reset shows the active-low default: pin high means enabled drive
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            inh_reg   <= {AXES{1'b1}};
            servo_reg <= '0;
        end else begin
            for (int a = 0; a < AXES; a++) begin
                inh_reg[a] <= inh_act[a] ~^ ctrl_reg[a][acos_pkg::CTRL_INH_POL];
            end
            servo_reg <= servo_next;
        end
    end

    // step channels, one per axis
    for (genvar a = 0; a < AXES; a++) begin : g_axis
        assign ch[a].mode_ccw       = ctrl_reg[a][acos_pkg::CTRL_MODE_CCW];
        assign ch[a].pulse_pol_high = ctrl_reg[a][acos_pkg::CTRL_PUL_POL];
        assign ch[a].dir_pol_high   = ctrl_reg[a][acos_pkg::CTRL_DIR_POL];
        assign ch[a].block          = killed_reg[a];
        assign ch[a].width          = width_reg;
        assign ch[a].step_valid     = step_valid_i[a];
        assign ch[a].step_fwd       = step_fwd_i[a];
        assign step_ready_o[a]        = ch[a].step_ready;
        assign pulse_forward_out_o[a] = ch[a].pulse_pin;
        assign sense_reverse_out_o[a] = ch[a].reverse_pin;
        // interface arrays take only constant indices, so the read mux sees plain vectors
        assign busy_w[a]              = ch[a].busy;
        assign count_w[a]             = ch[a].step_count;

        acos_step_chan u_chan (
            .clk_i     (clk_i),
            .reset_n_i (reset_n_i),
            .c         (ch[a])
        );
    end

    // read mux; unmapped reads answer zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (reg_addr_i == acos_pkg::ADDR_WIDTH) begin
            rd_val = {16'h0000, width_reg};
        end else if (reg_addr_i == acos_pkg::ADDR_KSTAT) begin
            rd_val = 32'(killed_reg);
        end
        for (int a = 0; a < AXES; a++) begin
            if (reg_addr_i == axis_addr(a, acos_pkg::OFF_CTRL)) begin
                rd_val = 32'(ctrl_reg[a]);
            end else if (reg_addr_i == axis_addr(a, acos_pkg::OFF_POS_LIM)) begin
                rd_val = {16'h0000, pos_reg[a]};
            end else if (reg_addr_i == axis_addr(a, acos_pkg::OFF_NEG_LIM)) begin
                rd_val = {16'h0000, neg_reg[a]};
            end else if (reg_addr_i == axis_addr(a, acos_pkg::OFF_OFFSET)) begin
                rd_val = {16'h0000, off_reg[a]};
            end else if (reg_addr_i == axis_addr(a, acos_pkg::OFF_DIRECT)) begin
                rd_val = {16'h0000, direct_reg[a]};
            end else if (reg_addr_i == axis_addr(a, acos_pkg::OFF_STATUS)) begin
                rd_val = {29'h0000_0000, inh_act[a], busy_w[a], killed_reg[a]};
            end else if (reg_addr_i == axis_addr(a, acos_pkg::OFF_STEPS)) begin
                rd_val = {16'h0000, count_w[a]};
            end
        end
    end

    // read data only stands in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= reg_rd_i ? rd_val : 32'h0000_0000;
        end
    end

    assign reg_rdata_o   = rdata_reg;
    assign inhibit_out_o = inh_reg;
    assign servo_value_o = servo_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    kill_all_a: assert property ((shutdown_i || stop_all_i) |=> killed_reg == {AXES{1'b1}})
        else $error("shutdown or stop-all did not kill every axis");
    read_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
        else $error("read data outside the answer cycle");

    for (genvar a = 0; a < AXES; a++) begin : g_chk
        auto_inh_a: assert property ((killed_reg[a] && ctrl_reg[a][acos_pkg::CTRL_AUTO_INH])
                |=> inhibit_out_o[a] == $past(ctrl_reg[a][acos_pkg::CTRL_INH_POL]))
            else $error("killed axis drive not disabled");
        sw_inh_a: assert property ((!ctrl_reg[a][acos_pkg::CTRL_INH_SW] && !killed_reg[a])
                |=> inhibit_out_o[a] != $past(ctrl_reg[a][acos_pkg::CTRL_INH_POL]))
            else $error("drive disabled without cause");
        servo_clamp_a: assert property ((ctrl_reg[a][acos_pkg::CTRL_MAPPED]
                && $signed(servo_cmd_i[a]) > $signed(pos_reg[a]))
                |=> servo_value_o[a] == sat_add($past(pos_reg[a]), $past(off_reg[a])))
            else $error("servo value not clamped to positive limit");
        servo_direct_a: assert property (!ctrl_reg[a][acos_pkg::CTRL_MAPPED]
                |=> servo_value_o[a] == $past(direct_reg[a]))
            else $error("unmapped servo value not taken from software");
    end

endmodule : axis_command_output_stage

// ===== tb/acos_drive_model.sv
// drive model: counts the pulses it sees on the step pins
// assumes the bench tells it the active level of each pin
`timescale 1ns/1ps
module acos_drive_model (
    // pins and polarity
    input  wire logic       clk_i,
    input  wire logic [3:0] fwd_pin_i,
    input  wire logic [3:0] rev_pin_i,
    input  wire logic [3:0] fwd_pol_i,
    input  wire logic [3:0] rev_pol_i,
    // pulse counts
    output logic [3:0][15:0] fwd_cnt_o,
    output logic [3:0][15:0] rev_cnt_o
);
    logic [3:0] fp = '0;
    logic [3:0] rp = '0;
    initial fwd_cnt_o = '0;
    initial rev_cnt_o = '0;
    // a pulse counts once, at the first cycle it is seen active
    always @(posedge clk_i) begin
        for (int a = 0; a < 4; a++) begin
            if (fwd_pin_i[a] === fwd_pol_i[a] && fp[a] !== fwd_pol_i[a]) fwd_cnt_o[a]++;
            if (rev_pin_i[a] === rev_pol_i[a] && rp[a] !== rev_pol_i[a]) rev_cnt_o[a]++;
        end
        fp <= fwd_pin_i;
        rp <= rev_pin_i;
    end
endmodule : acos_drive_model

// ===== tb/axis_command_output_stage_tb.sv
// bench for the four-axis command output stage
// assumes the drive model beside it counts pin pulses
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module axis_command_output_stage_tb;
    logic clk_i = 0, reset_n_i = 0, wr = 0, rd = 0, sd = 0, sa = 0, lf;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [3:0] sv = '0, sf = '0, me = '0, sr, pf, pr, inh, fpol = '0, rpol = '0;
    logic [3:0][15:0] cmd = '0, sval, fc, rc;
    logic [15:0] f0, r0, x;
    int mismatches = 0, total_checks = 0, cyc = 0, seed = 64168, n, nf, nr;
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h80, 8'hfc};
    logic [31:0] rv [5] = '{32'h60, 32'h7fff, 32'h8000, 32'hc8, 32'h0};
    logic [7:0] iv [3] = '{8'h70, 8'h78, 8'h68};
    always #2.5 clk_i = ~clk_i;
    axis_command_output_stage u_axis_command_output_stage (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .step_valid_i(sv), .step_fwd_i(sf), .step_ready_o(sr), .servo_cmd_i(cmd),
        .shutdown_i(sd), .stop_all_i(sa), .motion_err_i(me), .pulse_forward_out_o(pf),
        .sense_reverse_out_o(pr), .inhibit_out_o(inh), .servo_value_o(sval));
    acos_drive_model u_acos_drive_model (.clk_i(clk_i), .fwd_pin_i(pf), .rev_pin_i(pr),
        .fwd_pol_i(fpol), .rev_pol_i(rpol), .fwd_cnt_o(fc), .rev_cnt_o(rc));
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    always @(posedge clk_i) if (++cyc == 40000) begin mismatches++; conclude(); end
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        {addr, wdata, wr} <= {a, v, 1'b1};
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_i);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic wait_rdy(input int a);
        repeat (2) @(posedge clk_i);
        for (int k = 0; k < 500 && sr[a] !== 1'b1; k++) @(posedge clk_i);
        #1;
    endtask : wait_rdy
    // valid stays up until the edge that also sees ready
    task automatic step(input int a, input logic fw);
        @(posedge clk_i);
        {sv[a], sf[a]} <= {1'b1, fw};
        @(posedge clk_i);
        for (int k = 0; k < 500 && sr[a] !== 1'b1; k++) @(posedge clk_i);
        sv[a] <= 1'b0;
    endtask : step
    function automatic logic [15:0] exp_servo(input logic [15:0] c);
        int v;
        v = $signed(c);
        v = v > 256 ? 256 : (v < -256 ? -256 : v);
        return 16'(v + 16);
    endfunction : exp_servo
    initial begin
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd_reg(ra[i]);
            `CHK(d, rv[i])
        end
        wr_reg(8'h80, 32'h2);
        wr_reg(8'h00, 32'h66);
        wr_reg(8'h20, 32'h61);
        {fpol[0], rpol[0]} <= 2'b11;
        wait_rdy(0);
        {f0, n} = {fc[0], 8 + ($random(seed) & 7)};
        for (int i = 0; i < n; i++) begin
            lf = 1'($random(seed));
            step(0, lf);
        end
        wait_rdy(0);
        `CHK(fc[0] - f0, 16'(n))
        `CHK(pr[0], ~lf)
        `CHK({pf[1], pf[0]}, 2'b10)
        rd_reg(8'h18);
        `CHK(d, 32'(n))
        {f0, r0, nf, nr} = {fc[1], rc[1], 64'h0};
        for (int i = 0; i < 12; i++) begin
            lf = i < 2 ? i[0] : 1'($random(seed));
            step(1, lf);
            if (lf) nf++;
            else nr++;
        end
        wait_rdy(1);
        `CHK({fc[1] - f0, rc[1] - r0}, {16'(nf), 16'(nr)})
        for (int i = 0; i < 3; i++) begin
            wr_reg(8'h40, 32'(iv[i]));
            repeat (2) @(posedge clk_i);
            #1 `CHK(inh[2], i == 1)
        end
        wr_reg(8'h40, 32'h60);
        for (int s = 0; s < 3; s++) begin
            @(posedge clk_i);
            {sa, sd, me[2]} <= {s == 0, s == 1, s == 2};
            @(posedge clk_i);
            {sa, sd, me} <= '0;
            repeat (3) @(posedge clk_i);
            #1 `CHK({inh[2], sr[2]}, 2'b00)
            rd_reg(8'h88);
            `CHK(d, s == 2 ? 32'h4 : 32'hf)
            rd_reg(8'h54);
            `CHK(d, 32'h5)
            wr_reg(8'h84, 32'hf);
            repeat (3) @(posedge clk_i);
            #1 `CHK({inh[2], sr[2]}, 2'b11)
        end
        wr_reg(8'h64, 32'h100);
        wr_reg(8'h68, 32'hff00);
        wr_reg(8'h6c, 32'h10);
        for (int i = 0; i < 10; i++) begin
            x = i == 0 ? 16'h7fff : (i == 1 ? 16'h8000 : 16'($random(seed)));
            @(posedge clk_i);
            cmd[3] <= x;
            repeat (2) @(posedge clk_i);
            #1 `CHK(sval[3], exp_servo(x))
        end
        wr_reg(8'h60, 32'h20);
        wr_reg(8'h70, 32'h1234);
        repeat (2) @(posedge clk_i);
        #1 `CHK(sval[3], 16'h1234)
        conclude();
    end
endmodule : axis_command_output_stage_tb
